// File: logic/csab_regs.vh
// constants of the core special-function register bank
// assumes inclusion by the single design file of the bank
`ifndef CSAB_REGS_VH
`define CSAB_REGS_VH
// r-page core register offsets
`define CSAB_ADDR_INDIRECT   7'h00
`define CSAB_ADDR_TIMER0     7'h01
`define CSAB_ADDR_PCLOW      7'h02
`define CSAB_ADDR_STATUS     7'h03
`define CSAB_ADDR_POINTER    7'h04
`define CSAB_ADDR_PORT_A_DATA      7'h05
`define CSAB_ADDR_PORT_B_DATA      7'h06
`define CSAB_ADDR_PROGRAM_COUNTER_HIGH_BUFFER     7'h0a
`define CSAB_CORE_TOP        7'h1f
// status field positions
`define CSAB_ST_CARRY        0
`define CSAB_ST_HALF         1
`define CSAB_ST_ZERO         2
`define CSAB_ST_PD           3
`define CSAB_ST_TO           4
`define CSAB_ST_SPARE        5
`define CSAB_ST_BANK_LO      6
`define CSAB_ST_BANK_HI      7
// reset values
`define CSAB_RST_STATUS      8'h18
`define CSAB_RST_POINTER     8'h00
`define CSAB_RST_PCLOW       8'h00
`define CSAB_RST_PROGRAM_COUNTER_HIGH_BUFFER      3'h0
`define CSAB_RST_PC          11'h000
`define CSAB_RST_TIMER0      8'h00
`define CSAB_RST_LATCH       8'h00
// special and configuration page decode
`define CSAB_SP_LAST         5'h18
`define CSAB_SP_HOLE         5'h17
`define CSAB_CFG_MAP         16'hd660
// instruction classes from the core
`define CSAB_OP_NONE         3'h0
`define CSAB_OP_DATA         3'h1
`define CSAB_OP_CFG_WR       3'h2
`define CSAB_OP_CFG_RD       3'h3
`define CSAB_OP_SP_WR        3'h4
`define CSAB_OP_SP_RD        3'h5
// program counter control
`define CSAB_PC_STEP         2'h0
`define CSAB_PC_HOLD         2'h1
`define CSAB_PC_LONG         2'h2
// timer0 clock selections
`define CSAB_T0_INST         2'h0
`define CSAB_T0_EXT          2'h1
`define CSAB_T0_LOWOSC       2'h2
`endif

// File: logic/csab_bank.v
// core special-function register bank: page decode, indirect access,
// timer0, pc, status, pointer and port data registers.
// assumes one system clock shared with the execution core; the core
// presents one access per cycle and reads data combinationally.
//
// Overview of operation
// - configuration page reached only by its two dedicated transfer instructions
// - special page reached only by its dedicated write and read instructions
// - bank select bits ignored on configuration and special page access
// - special page decodes 0x0 to 0x18 less 0x17; config page at listed seven
// - indirect port has no storage; access goes to pointer-selected register
// - timer0 read returns live count; write replaces count at once
// - timer0 clock selected from instruction clock, external pin or low oscillator
// - pc low byte is 11-bit pc bits 7:0, resets zero, steps per instruction
// - pc bits 10:8 not directly accessible; loaded through high buffer
// - long jump loads all eleven pc bits from instruction word
// - long call loads pc from word and pushes next address on stack
// - carry set on add carry or subtract without borrow
// - half carry set on low-nibble carry or no low-nibble borrow
// - zero flag set when result is zero, cleared otherwise
// - power-down flag set at power-up and watchdog clear, cleared by sleep
// - timeout flag set at power-up, watchdog clear or sleep; cleared on timeout
// - two bank bits select data bank 0 to 3, reset to 00b
// - pointer low seven bits select register; bit 7 is spare storage
// - port a read gives pin for inputs, pin or latch for outputs by option
// - port a write updates only output latches
// - port b acts like port a on six pin bits
// - port b bits 7 and 6 are plain storage, not pins
// - indirect bank from status, location from pointer; direct from opcode
// - core page lives only at 0x0 to 0x1f of bank 0, mirrored in others
`include "csab_regs.vh"
`timescale 1ns/10ps
`default_nettype none

module csab_bank (
  input  wire        clock,          // system clock, 125 mhz
  input  wire        srst,           // synchronous reset, active high
  input  wire [2:0]  op_class,       // instruction class of this access
  input  wire [6:0]  op_addr,        // opcode address bits 6:0
  input  wire        op_wr,          // data-class access writes
  input  wire        op_rd,          // data-class access reads
  input  wire [7:0]  wr_data,        // write data from the core
  output reg  [7:0]  rd_data,        // read data to the core
  output reg  [8:0]  gpr_addr,       // bank and location for general memory
  output wire        gpr_wr,         // general memory write strobe
  output wire        gpr_rd,         // general memory read strobe
  input  wire [7:0]  gpr_rdata,      // general memory read data
  output wire        cfg_wr,         // configuration page write strobe
  output wire        sp_wr,          // special page write strobe
  output wire [4:0]  page_addr,      // address within cfg or special page
  input  wire [7:0]  cfg_rdata,      // configuration page read data
  input  wire [7:0]  sp_rdata,       // special page read data
  output wire        periph_wr,      // other core-page register write strobe
  input  wire [7:0]  periph_rdata,   // other core-page register read data
  input  wire        instr_done,     // one instruction completed
  input  wire [1:0]  pc_ctl,         // step, hold or long load
  input  wire [10:0] long_target,    // long jump or call target
  input  wire        long_call,      // long load is a call
  output reg  [10:0] pc,             // program counter
  output wire        push_valid,     // push return address
  output wire [10:0] push_addr,      // return address pushed
  input  wire        flag_wr,        // arithmetic result flags valid
  input  wire        flag_add,       // operation is an addition
  input  wire        carry_out,      // adder carry out of bit 7
  input  wire        half_out,       // adder carry out of bit 3
  input  wire        result_zero,    // operation result is zero
  input  wire        zero_only,      // logical op: only zero flag
  input  wire        clrwdt_exec,    // watchdog clear instruction
  input  wire        sleep_exec,     // sleep instruction
  input  wire        wdt_timeout,    // watchdog timed out
  input  wire        t0_mode,        // timer0 mode bit
  input  wire        t0_cfg_lowosc,  // configuration word picks low osc
  input  wire        tick_inst,      // instruction clock tick
  input  wire        tick_ext,       // external clock pin rising edge
  input  wire        tick_lowosc,    // low oscillator tick
  input  wire        read_latch_opt, // 1: output pins read the latch
  input  wire [7:0]  port_a_data_pins,     // port a pin levels
  input  wire [7:0]  port_a_data_dir_out,  // port a direction, 1 output
  input  wire [5:0]  port_b_data_pins,     // port b pin levels
  input  wire [5:0]  port_b_data_dir_out,  // port b direction, 1 output
  output reg  [7:0]  port_a_data_latch,    // port a output data latch
  output reg  [7:0]  port_b_data_latch,    // port b latch, bits 7:6 storage
  output reg  [7:0]  status,         // status register
  output reg  [7:0]  pointer,        // indirect pointer
  output reg  [7:0]  timer0          // timer0 running count
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  reg  [2:0]  program_counter_high_buffer;
  wire        is_data = (op_class == `CSAB_OP_DATA);
  wire        is_cfg  = (op_class == `CSAB_OP_CFG_WR) | (op_class == `CSAB_OP_CFG_RD);
  wire        is_sp   = (op_class == `CSAB_OP_SP_WR) | (op_class == `CSAB_OP_SP_RD);

  // indirect access takes pointer location; bank always from status
  wire        via_ptr = (op_addr == `CSAB_ADDR_INDIRECT);
  wire [6:0]  eff_loc = via_ptr ? pointer[6:0] : op_addr;
  wire [1:0]  bank    = status[`CSAB_ST_BANK_HI:`CSAB_ST_BANK_LO];
  // core page mirrored in every bank, so bank bits ignored there
  wire        core_hit = is_data & (eff_loc <= `CSAB_CORE_TOP);
  // core page address pointing back at the indirect port hits nothing
  wire        null_ind = core_hit & (eff_loc == `CSAB_ADDR_INDIRECT);

  // map of the seven live configuration addresses, one bit per address
  localparam [15:0] CFG_MAP = `CSAB_CFG_MAP;

  // page decodes use opcode bits only; bank never enters here
  function page_valid;
    input       cfg;
    input [4:0] a;
    begin
      if (cfg)
        page_valid = (a[4] == 1'b0) && CFG_MAP[a[3:0]];
      else
        page_valid = (a <= `CSAB_SP_LAST) && (a != `CSAB_SP_HOLE);
    end
  endfunction

  assign page_addr = op_addr[4:0];
  wire   page_ok   = (op_addr[6:5] == 2'b00) & page_valid(is_cfg, page_addr);
  // only the dedicated instructions strobe the extra pages
  assign cfg_wr = (op_class == `CSAB_OP_CFG_WR) & page_ok;
  assign sp_wr  = (op_class == `CSAB_OP_SP_WR) & page_ok;

  wire wr_core = is_data & op_wr & core_hit & ~null_ind;
  assign gpr_wr = is_data & op_wr & ~core_hit;
  assign gpr_rd = is_data & op_rd & ~core_hit;
  wire   hit_own = (eff_loc == `CSAB_ADDR_TIMER0) | (eff_loc == `CSAB_ADDR_PCLOW) |
                   (eff_loc == `CSAB_ADDR_STATUS) | (eff_loc == `CSAB_ADDR_POINTER) |
                   (eff_loc == `CSAB_ADDR_PORT_A_DATA) | (eff_loc == `CSAB_ADDR_PORT_B_DATA) |
                   (eff_loc == `CSAB_ADDR_PROGRAM_COUNTER_HIGH_BUFFER);
  assign periph_wr = wr_core & ~hit_own;

  // general memory address formed from bank and location
  always @* begin
    gpr_addr = {bank, eff_loc};
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  // per-bit port read: inputs give pin, outputs give pin or latch
  function [7:0] port_view;
    input [7:0] pins;
    input [7:0] dir;
    input [7:0] latch;
    input       opt;
    begin
      port_view = (pins & ~dir) | ((opt ? latch : pins) & dir);
    end
  endfunction

  // port b pins padded to a byte; only bits 5:0 reach the read mux
  wire [7:0] port_b_data_view = port_view({2'b00, port_b_data_pins}, {2'b00, port_b_data_dir_out},
                                    port_b_data_latch, read_latch_opt);

  always @* begin
    rd_data = 8'h00;
    if (op_class == `CSAB_OP_CFG_RD)
      rd_data = page_ok ? cfg_rdata : 8'h00;
    else if (op_class == `CSAB_OP_SP_RD)
      rd_data = page_ok ? sp_rdata : 8'h00;
    else if (is_data & ~core_hit)
      rd_data = gpr_rdata;
    else if (is_data) begin
      case (eff_loc)
        `CSAB_ADDR_INDIRECT: rd_data = 8'h00;
        `CSAB_ADDR_TIMER0:   rd_data = timer0;
        `CSAB_ADDR_PCLOW:    rd_data = pc[7:0];
        `CSAB_ADDR_STATUS:   rd_data = status;
        `CSAB_ADDR_POINTER:  rd_data = pointer;
        `CSAB_ADDR_PORT_A_DATA:    rd_data = port_view(port_a_data_pins, port_a_data_dir_out,
                                                 port_a_data_latch, read_latch_opt);
        `CSAB_ADDR_PORT_B_DATA:    rd_data = {port_b_data_latch[7:6], port_b_data_view[5:0]};
        `CSAB_ADDR_PROGRAM_COUNTER_HIGH_BUFFER:   rd_data = 8'h00;
        default:             rd_data = periph_rdata;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer0

  reg tick_sel;
  // mode bit chooses external pin; otherwise config word picks source
  always @* begin
    if (t0_mode)
      tick_sel = tick_ext;
    else if (t0_cfg_lowosc)
      tick_sel = tick_lowosc;
    else
      tick_sel = tick_inst;
  end

  // software write wins over a count tick in the same cycle
  always @(posedge clock) begin
    if (srst)
      timer0 <= `CSAB_RST_TIMER0;
    else if (wr_core & (eff_loc == `CSAB_ADDR_TIMER0))
      timer0 <= wr_data;
    else if (tick_sel)
      timer0 <= timer0 + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter

  assign push_valid = instr_done & (pc_ctl == `CSAB_PC_LONG) & long_call;
  assign push_addr  = pc + 11'h001;

  // writing the low byte jumps using the high buffer for bits 10:8
  always @(posedge clock) begin
    if (srst) begin
      pc     <= `CSAB_RST_PC;
      program_counter_high_buffer <= `CSAB_RST_PROGRAM_COUNTER_HIGH_BUFFER;
    end else begin
      if (wr_core & (eff_loc == `CSAB_ADDR_PROGRAM_COUNTER_HIGH_BUFFER))
        program_counter_high_buffer <= wr_data[2:0];
      if (wr_core & (eff_loc == `CSAB_ADDR_PCLOW))
        pc <= {program_counter_high_buffer, wr_data};
      else if (instr_done) begin
        case (pc_ctl)
          `CSAB_PC_STEP: pc <= pc + 11'h001;
          `CSAB_PC_LONG: pc <= long_target;
          default:       pc <= pc;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status, pointer, ports

  // hardware events apply after a software write so they are never lost
  always @(posedge clock) begin
    if (srst)
      status <= `CSAB_RST_STATUS;
    else begin
      if (wr_core & (eff_loc == `CSAB_ADDR_STATUS))
        status <= wr_data;
      if (flag_wr) begin
        status[`CSAB_ST_ZERO] <= result_zero;
        if (!zero_only) begin
          // subtract reports not-borrow, which is the adder carry
          status[`CSAB_ST_CARRY] <= carry_out;
          status[`CSAB_ST_HALF]  <= half_out;
        end
      end
      if (clrwdt_exec) begin
        status[`CSAB_ST_PD] <= 1'b1;
        status[`CSAB_ST_TO] <= 1'b1;
      end else if (sleep_exec) begin
        status[`CSAB_ST_PD] <= 1'b0;
        status[`CSAB_ST_TO] <= 1'b1;
      end else if (wdt_timeout)
        status[`CSAB_ST_TO] <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (srst) begin
      pointer     <= `CSAB_RST_POINTER;
      port_a_data_latch <= `CSAB_RST_LATCH;
      port_b_data_latch <= `CSAB_RST_LATCH;
    end else begin
      if (wr_core & (eff_loc == `CSAB_ADDR_POINTER))
        pointer <= wr_data;
      if (wr_core & (eff_loc == `CSAB_ADDR_PORT_A_DATA))
        port_a_data_latch <= wr_data;
      if (wr_core & (eff_loc == `CSAB_ADDR_PORT_B_DATA))
        port_b_data_latch <= wr_data;
    end
  end

endmodule // csab_bank

`default_nettype wire

// File: verification/csab_sva.sv
// checker for the core register bank, bound from the bench top
// assumes one clock and srst active high, synchronous
`timescale 1ns/10ps
`default_nettype none
module csab_sva (
  input wire logic        clock,       // system clock
  input wire logic        srst,        // sync reset
  input wire logic [2:0]  op_class,    // access class
  input wire logic [6:0]  op_addr,     // opcode address
  input wire logic        op_wr,       // data write
  input wire logic [7:0]  wr_data,     // write data
  input wire logic [8:0]  gpr_addr,    // bank, location
  input wire logic        gpr_wr,      // memory write
  input wire logic        cfg_wr,      // cfg strobe
  input wire logic        sp_wr,       // special strobe
  input wire logic        instr_done,  // step
  input wire logic [1:0]  pc_ctl,      // pc control
  input wire logic [10:0] long_target, // long target
  input wire logic        long_call,   // call
  input wire logic [10:0] pc,          // counter
  input wire logic        push_valid,  // push
  input wire logic [10:0] push_addr,   // return address
  input wire logic        flag_wr,     // flags valid
  input wire logic        result_zero, // zero result
  input wire logic        clrwdt_exec, // watchdog clear
  input wire logic        sleep_exec,  // sleep
  input wire logic        wdt_timeout, // timeout
  input wire logic [7:0]  port_a_data_latch, // port a latch
  input wire logic [7:0]  status,      // status
  input wire logic [7:0]  timer0       // timer count
);
  ////////////////////////////////////////////////////////////////////////////////
  // one domain, so clock and disable are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  localparam logic [15:0] CMAP = 16'hd660;
  wire logic dw = op_class == 3'h1 && op_wr;
  ////////////////////////////////////////////////////////////////////////////////
  // page strobes only for their own class and decoded addresses
  a_cfg_decode: assert property (cfg_wr == (op_class == 3'h2 && op_addr[6:4] == 3'h0 && CMAP[op_addr[3:0]]))
    else $error("cfg strobe wrong");
  a_sp_decode: assert property (sp_wr == (op_class == 3'h4 && op_addr <= 7'h18 && op_addr != 7'h17))
    else $error("special strobe wrong");
  a_gpr_route: assert property (dw && op_addr >= 7'h20 |-> gpr_wr && gpr_addr == {status[7:6], op_addr})
    else $error("memory route wrong");
  a_t0_write: assert property (dw && op_addr == 7'h01 |=> timer0 == $past(wr_data))
    else $error("timer write lost");
  a_port_a_data_latch: assert property (dw && op_addr == 7'h05 |=> port_a_data_latch == $past(wr_data))
    else $error("port a latch wrong");
  a_pc_step: assert property (instr_done && pc_ctl == 2'h0 && !dw |=> pc == $past(pc) + 11'h1)
    else $error("pc did not step");
  a_long_load: assert property (instr_done && pc_ctl == 2'h2 && !dw |=> pc == $past(long_target))
    else $error("long load wrong");
  a_call_push: assert property (instr_done && pc_ctl == 2'h2 && long_call |-> push_valid && push_addr == pc + 11'h1)
    else $error("push wrong");
  a_zero_flag: assert property (flag_wr |=> status[2] == $past(result_zero))
    else $error("zero flag wrong");
  a_sleep_flags: assert property (sleep_exec && !clrwdt_exec |=> status[4:3] == 2'b10)
    else $error("sleep flags wrong");
  a_clrwdt_flags: assert property (clrwdt_exec |=> status[4:3] == 2'b11)
    else $error("clear flags wrong");
  a_timeout_flag: assert property (wdt_timeout && !clrwdt_exec && !sleep_exec |=> !status[4])
    else $error("timeout flag wrong");
  c_push: cover property (push_valid);
  c_cfg: cover property (cfg_wr);
  c_sp: cover property (sp_wr);
endmodule // csab_sva
`default_nettype wire

// File: verification/csab_core_mem.sv
// far-side model: general memory and page read sources of the core
// assumes gpr_rdata is sampled only while gpr_rd is high
`timescale 1ns/10ps
`default_nettype none
module csab_core_mem (
  input wire logic        clock,        // system clock
  input wire logic [8:0]  gpr_addr,     // bank, location
  input wire logic        gpr_wr,       // write strobe
  input wire logic        gpr_rd,       // read strobe
  input wire logic [7:0]  wr_data,      // write data
  input wire logic [4:0]  page_addr,    // page address
  output wire logic [7:0] gpr_rdata,    // memory data
  output wire logic [7:0] cfg_rdata,    // cfg data
  output wire logic [7:0] sp_rdata,     // special data
  output wire logic [7:0] periph_rdata  // other core data
);
  logic [7:0] mem [0:511];
  logic [7:0] churn = 8'h00;
  // store writes; churn stands in for a bus nobody drives
  always @(posedge clock) begin
    churn <= churn + 8'h35;
    if (gpr_wr) mem[gpr_addr] <= wr_data;
  end
  // page sources carry their address so a wrong mux shows
  assign gpr_rdata = gpr_rd ? mem[gpr_addr] : churn;
  assign cfg_rdata = {3'h5, page_addr};
  assign sp_rdata = {3'h6, page_addr};
  assign periph_rdata = {3'h7, page_addr};
endmodule // csab_core_mem
`default_nettype wire

// File: verification/csab_bank_tb.sv
// bench for the core register bank: access tasks and check sequences
// assumes the far-side memory model and the bound checker
`timescale 1ns/10ps
`default_nettype none
module csab_bank_tb;
  logic        clock, op_wr, op_rd, instr_done, long_call, flag_wr, flag_add, carry_out;
  logic        half_out, result_zero, zero_only, clrwdt_exec, sleep_exec, wdt_timeout;
  logic        t0_mode, t0_cfg_lowosc, tick_inst, tick_ext, tick_lowosc, read_latch_opt;
  logic        gpr_wr, gpr_rd, cfg_wr, sp_wr, periph_wr, push_valid, cv, sv;
  logic        srst = 1'b1;
  logic [1:0]  pc_ctl;
  logic [2:0]  op_class;
  logic [4:0]  page_addr;
  logic [5:0]  port_b_data_pins, port_b_data_dir_out;
  logic [6:0]  op_addr;
  logic [7:0]  wr_data, rd_data, gpr_rdata, cfg_rdata, sp_rdata, periph_rdata, port_a_data_pins;
  logic [7:0]  port_a_data_dir_out, port_a_data_latch, port_b_data_latch, status, pointer, timer0;
  logic [8:0]  gpr_addr;
  logic [10:0] long_target, pc, push_addr;
  int          n_errors = 0;
  int          checked = 0;
  // flag vectors {add,carry,half,zero,zero only} and expected {z,dc,c}
  logic [4:0]  fv [4] = '{5'h18, 5'h06, 5'h1b, 5'h02};
  logic [2:0]  fe [4] = '{3'h1, 3'h6, 3'h6, 3'h4};
  csab_bank csab_bank_i (.*);
  csab_core_mem csab_core_mem_i (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog; run needs under two hundred cycles
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #20000;
    n_errors++;
    wrap_up();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // access tasks: inputs change 1 ns after the edge
  task cyc();
    @(posedge clock);
    #1;
  endtask
  task put(input logic [2:0] c, input logic [6:0] a, input logic w, input logic [7:0] d);
    op_class = c;
    op_addr = a;
    op_wr = w;
    op_rd = c == 3'h1 && !w;
    wr_data = d;
    #1;
  endtask
  task wr(input logic [2:0] c, input logic [6:0] a, input logic [7:0] d);
    put(c, a, 1'b1, d);
    cyc();
  endtask
  task rd(input logic [2:0] c, input logic [6:0] a, input logic [7:0] e);
    put(c, a, 1'b0, 8'h00);
    chk("rd_data", e, rd_data);
    cyc();
  endtask
  task idle();
    put(3'h0, 7'h00, 1'b0, 8'h00);
    cyc();
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task chk_pc(input string nm, input logic [10:0] e, input logic [10:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task wrap_up();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {op_wr, op_rd, instr_done, long_call, flag_wr, flag_add, carry_out, half_out, result_zero,
     zero_only, clrwdt_exec, sleep_exec, wdt_timeout, t0_mode, t0_cfg_lowosc, tick_inst,
     tick_ext, tick_lowosc, read_latch_opt, pc_ctl, op_class, port_b_data_pins, port_b_data_dir_out,
     op_addr, wr_data, port_a_data_pins, port_a_data_dir_out, long_target} = '0;
    repeat (8) cyc();
    srst = 1'b0;
    chk("status", 8'h18, status);
    chk("pointer", 8'h00, pointer);
    rd(3'h1, 7'h02, 8'h00);
    // steps, then high buffer and low byte, then long call and jump
    instr_done = 1'b1;
    repeat (3) idle();
    chk_pc("pc", 11'h003, pc);
    instr_done = 1'b0;
    wr(3'h1, 7'h0a, 8'h05);
    wr(3'h1, 7'h02, 8'h34);
    rd(3'h1, 7'h0a, 8'h00);
    chk_pc("pc", 11'h534, pc);
    {instr_done, pc_ctl, long_call, long_target} = {1'b1, 2'h2, 1'b1, 11'h7a5};
    #1 chk("push_valid", 8'h01, {7'h0, push_valid});
    chk_pc("push_addr", 11'h535, push_addr);
    idle();
    chk_pc("pc", 11'h7a5, pc);
    {long_call, long_target} = {1'b0, 11'h123};
    idle();
    chk_pc("pc", 11'h123, pc);
    pc_ctl = 2'h1;
    idle();
    chk_pc("pc", 11'h123, pc);
    {instr_done, pc_ctl} = 3'h0;
    // power flags: sleep, timeout, then clear
    sleep_exec = 1'b1;
    idle();
    chk("status", 8'h10, status & 8'h18);
    {sleep_exec, wdt_timeout} = 2'b01;
    idle();
    chk("status", 8'h00, status & 8'h18);
    {wdt_timeout, clrwdt_exec} = 2'b01;
    idle();
    chk("status", 8'h18, status & 8'h18);
    clrwdt_exec = 1'b0;
    // arithmetic flags {add,carry,half,zero,zero only}; third keeps carry bits
    flag_wr = 1'b1;
    foreach (fv[i]) begin
      {flag_add, carry_out, half_out, result_zero, zero_only} = fv[i];
      idle();
      chk("flags", {5'h0, fe[i]}, {5'h0, status[2:0]});
    end
    flag_wr = 1'b0;
    // banks, direct and indirect access
    wr(3'h1, 7'h30, 8'h11);
    wr(3'h1, 7'h03, 8'h58);
    rd(3'h1, 7'h03, 8'h58);
    wr(3'h1, 7'h30, 8'h5a);
    wr(3'h1, 7'h04, 8'hb0);
    rd(3'h1, 7'h00, 8'h5a);
    rd(3'h1, 7'h04, 8'hb0);
    wr(3'h1, 7'h03, 8'h18);
    rd(3'h1, 7'h00, 8'h11);
    wr(3'h1, 7'h03, 8'hd8);
    // every page address with bank 3 selected
    for (int a = 0; a < 32; a++) begin
      cv = a inside {5, 6, 9, 10, 12, 14, 15};
      sv = a <= 24 && a != 23;
      put(3'h2, 7'(a), 1'b0, 8'h00);
      chk("cfg_wr", {7'h0, cv}, {7'h0, cfg_wr});
      cyc();
      rd(3'h3, 7'(a), cv ? {3'h5, 5'(a)} : 8'h00);
      put(3'h4, 7'(a), 1'b0, 8'h00);
      chk("sp_wr", {7'h0, sv}, {7'h0, sp_wr});
      cyc();
      rd(3'h5, 7'(a), sv ? {3'h6, 5'(a)} : 8'h00);
    end
    // timer from each source; the other two ticks must not count
    for (int m = 0; m < 3; m++) begin
      {t0_cfg_lowosc, t0_mode} = {m == 2, m == 1};
      wr(3'h1, 7'h01, 8'hfe);
      for (int k = 0; k < 4; k++) begin
        {tick_lowosc, tick_ext, tick_inst} = k < 2 ? 3'h1 << m : ~(3'h1 << m);
        idle();
      end
      {tick_lowosc, tick_ext, tick_inst} = 3'h0;
      rd(3'h1, 7'h01, 8'h00);
    end
    // ports: low nibble of a and low three of b are outputs
    {port_a_data_dir_out, port_a_data_pins, port_b_data_dir_out, port_b_data_pins} = {16'h0fa5, 12'h1ea};
    wr(3'h1, 7'h05, 8'h3c);
    rd(3'h1, 7'h05, 8'ha5);
    chk("port_a_data_latch", 8'h3c, port_a_data_latch);
    read_latch_opt = 1'b1;
    rd(3'h1, 7'h05, 8'hac);
    wr(3'h1, 7'h06, 8'hd5);
    rd(3'h1, 7'h06, 8'hed);
    read_latch_opt = 1'b0;
    rd(3'h1, 7'h06, 8'hea);
    wrap_up();
  end
endmodule // csab_bank_tb
bind csab_bank csab_sva csab_sva_i (.*);
`default_nettype wire
